// [inc/qhbc_pkg.sv]
package qhbc_pkg;

   // channel count and timing
   localparam int QHBC_CH       = 4;
   localparam int QHBC_CLK_NS   = 10;
   localparam int QHBC_DGL_NS   = 5000;
   localparam int QHBC_WAKE_NS  = 1000000;
   localparam int QHBC_DGL_W    = 9;
   localparam int QHBC_WAKE_W   = 17;
   // least time: deglitch rounds up, wake divides down
   localparam logic [QHBC_DGL_W-1:0]  QHBC_DGL_CYC  =
      QHBC_DGL_W'((QHBC_DGL_NS + QHBC_CLK_NS - 1) / QHBC_CLK_NS);
   localparam logic [QHBC_WAKE_W-1:0] QHBC_WAKE_CYC =
      QHBC_WAKE_W'(QHBC_WAKE_NS / QHBC_CLK_NS);

   // register byte addresses
   localparam logic [7:0] QHBC_ADR_STATUS = 8'h00;
   localparam logic [7:0] QHBC_ADR_MASK   = 8'h04;
   localparam logic [7:0] QHBC_ADR_STATE  = 8'h08;
   localparam logic [7:0] QHBC_ADR_CTRL   = 8'h0C;

   // event bits of status and mask
   localparam int QHBC_EV_OCP    = 0;
   localparam int QHBC_EV_THERM  = 4;
   localparam int QHBC_EV_SUPPLY = 5;
   localparam int QHBC_EV_W      = 6;
   localparam logic [QHBC_EV_W-1:0] QHBC_EV_NONE = 6'h00;

   typedef struct packed {
      logic [QHBC_CH-1:0] phase_input;
      logic [QHBC_CH-1:0] drive_enable_input;
      logic [QHBC_CH-1:0] hs_limit;
      logic [QHBC_CH-1:0] ls_limit;
   } qhbc_bridge_in_t;

   typedef struct packed {
      logic [QHBC_CH-1:0] high_side_on;
      logic [QHBC_CH-1:0] low_side_on;
   } qhbc_gate_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } qhbc_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } qhbc_apb_rsp_t;

   typedef struct packed {
      qhbc_gate_t             gate;
      logic [QHBC_CH-1:0]     ocp_latched;
      logic                   flag_oe;
      logic                   pump_run;
      logic                   therm_seen;
      logic                   supply_seen;
      logic [QHBC_CH-1:0]     inhibit;
      logic [QHBC_WAKE_W-1:0] wake_cnt;
      logic                   awake;
      qhbc_apb_rsp_t          rsp;
   } qhbc_core_t;

   typedef struct packed {
      logic [QHBC_DGL_W-1:0] cnt;
      logic                  trip;
   } qhbc_dgl_t;

   typedef struct packed {
      logic [QHBC_EV_W-1:0] status;
      logic [QHBC_EV_W-1:0] mask;
      logic                 irq;
   } qhbc_irq_t;

   localparam qhbc_core_t QHBC_CORE_RST = '{flag_oe: 1'b1, default: '0};
   localparam qhbc_dgl_t  QHBC_DGL_RST  = '0;
   localparam qhbc_irq_t  QHBC_IRQ_RST  = '0;

endpackage

// [rtl/qhbc_deglitch.sv]
`timescale 1ns/100ps
module qhbc_deglitch #(
   parameter logic [qhbc_pkg::QHBC_DGL_W-1:0] CYC = qhbc_pkg::QHBC_DGL_CYC
) (
   // clock and reset
   input  logic clk,
   input  logic sys_rst,
   // limit in, trip out
   input  logic clear,
   input  logic level,
   output logic trip
);
   import qhbc_pkg::*;

   qhbc_dgl_t st;
   qhbc_dgl_t next_st;

   always_comb begin
      next_st = st;
      if (clear || !level) begin
         next_st.cnt  = '0;
         next_st.trip = 1'b0;
      end else if (st.cnt == CYC - 1'b1) begin
         // counter parks here, trip holds while the limit stays
         next_st.trip = 1'b1;
      end else begin
         next_st.cnt  = st.cnt + 1'b1;
         next_st.trip = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= QHBC_DGL_RST;
      end else begin
         st <= next_st;
      end
   end

   assign trip = st.trip;

   AST_DGL_FULL_RUN: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(trip) |-> $past(st.cnt) == CYC - 1'b1 && $past(level))
      else $error("trip without a full deglitch run");

endmodule

// [rtl/qhbc_irq.sv]
`timescale 1ns/100ps
module qhbc_irq (
   // clock and reset
   input  logic                           clk,
   input  logic                           sys_rst,
   // events and software access
   input  logic [qhbc_pkg::QHBC_EV_W-1:0] ev_set,
   input  logic [qhbc_pkg::QHBC_EV_W-1:0] w1c,
   input  logic                           mask_we,
   input  logic [qhbc_pkg::QHBC_EV_W-1:0] mask_wdata,
   // state out
   output logic [qhbc_pkg::QHBC_EV_W-1:0] status,
   output logic [qhbc_pkg::QHBC_EV_W-1:0] mask,
   output logic                           irq
);
   import qhbc_pkg::*;

   qhbc_irq_t st;
   qhbc_irq_t next_st;

   always_comb begin
      next_st = st;
      // a new event beats a clear in the same cycle
      next_st.status = (st.status & ~w1c) | ev_set;
      if (mask_we) begin
         next_st.mask = mask_wdata;
      end
      next_st.irq = |(next_st.status & next_st.mask);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= QHBC_IRQ_RST;
      end else begin
         st <= next_st;
      end
   end

   assign status = st.status;
   assign mask   = st.mask;
   assign irq    = st.irq;

   AST_IRQ_SET_WINS: assert property (@(posedge clk) disable iff (sys_rst)
      ev_set != QHBC_EV_NONE |=> (status & $past(ev_set)) == $past(ev_set))
      else $error("event lost against clear");
   AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
      irq == |(status & mask))
      else $error("interrupt level disagrees with status and mask");

endmodule

// [rtl/qhbc_core.sv]
`timescale 1ns/100ps
// Function
// - enable low puts output in high impedance
// - enabled output follows phase input level
// - fast decay floats, slow decay shorts winding
// - lasting overcurrent disables channel, asserts fault
// - overcurrent latch held until clear or power
// - either transistor side can trip overcurrent
// - thermal trip disables all, resumes when cool
// - supply low disables, resets logic, flags fault
// - logic clear low resets and disables all
// - sleep stops bridges, pump, clocks, inputs
// - overcurrent deglitch lasts about 5 microseconds
module qhbc_core #(
   parameter logic [qhbc_pkg::QHBC_DGL_W-1:0]  DGL_CYC  = qhbc_pkg::QHBC_DGL_CYC,
   parameter logic [qhbc_pkg::QHBC_WAKE_W-1:0] WAKE_CYC = qhbc_pkg::QHBC_WAKE_CYC
) (
   // clock and reset
   input  logic                      clk,
   input  logic                      sys_rst,
   // controller pins
   input  qhbc_pkg::qhbc_bridge_in_t bridge_in,
   input  logic                      logic_clear_n,
   input  logic                      low_power_request_n,
   // protection sensors
   input  logic                      thermal_trip,
   input  logic                      supply_low_lockout,
   // half-bridge gate drive
   output qhbc_pkg::qhbc_gate_t      half_bridge_output,
   // open-drain fault pin
   output logic                      trouble_indicator_n_o,
   output logic                      trouble_indicator_n_oe,
   // power control
   output logic                      charge_pump_run,
   output logic                      clocks_run,
   // register bus
   input  qhbc_pkg::qhbc_apb_req_t   apb_req,
   output qhbc_pkg::qhbc_apb_rsp_t   apb_rsp,
   // interrupt
   output logic                      irq
);
   import qhbc_pkg::*;

   qhbc_core_t           st;
   qhbc_core_t           next_st;
   logic [QHBC_CH-1:0]   limit_any;
   logic [QHBC_CH-1:0]   overcurrent_trip;
   logic [QHBC_CH-1:0]   chan_on;
   logic                 hold_clear;
   logic                 asleep;
   logic                 run;
   logic                 fault_now;
   logic                 setup;
   logic                 access_done;
   logic                 wr_en;
   logic                 mask_we;
   logic [QHBC_EV_W-1:0] ev_set;
   logic [QHBC_EV_W-1:0] w1c;
   logic [QHBC_EV_W-1:0] status;
   logic [QHBC_EV_W-1:0] mask;

   assign limit_any = bridge_in.hs_limit | bridge_in.ls_limit;

   assign hold_clear = !logic_clear_n || supply_low_lockout;
   assign asleep     = !low_power_request_n;

   assign run = logic_clear_n && low_power_request_n && !thermal_trip &&
                !supply_low_lockout && st.awake;

   genvar g;
   generate
      for (g = 0; g < QHBC_CH; g++) begin : g_chan
         qhbc_deglitch #(
            .CYC(DGL_CYC)
         ) u_dgl (
            .clk    (clk),
            .sys_rst(sys_rst),
            .clear  (hold_clear || asleep),
            .level  (limit_any[g]),
            .trip   (overcurrent_trip[g])
         );
      end
   endgenerate

   // APB handshake: one wait-free access phase
   assign setup       = apb_req.psel && !apb_req.penable;
   assign access_done = apb_req.psel && apb_req.penable && st.rsp.pready;
   assign wr_en       = access_done && apb_req.pwrite;
   assign mask_we     = wr_en && apb_req.paddr == QHBC_ADR_MASK;
   assign w1c         = (wr_en && apb_req.paddr == QHBC_ADR_STATUS) ?
                        apb_req.pwdata[QHBC_EV_W-1:0] : QHBC_EV_NONE;

   always_comb begin
      next_st = st;
      if (hold_clear) begin
         next_st.ocp_latched = '0;
      end else begin
         next_st.ocp_latched = st.ocp_latched | overcurrent_trip;
      end

      if (asleep) begin
         next_st.wake_cnt = '0;
         next_st.awake    = 1'b0;
      end else if (!st.awake) begin
         if (st.wake_cnt == WAKE_CYC - 1'b1) begin
            next_st.awake = 1'b1;
         end else begin
            next_st.wake_cnt = st.wake_cnt + 1'b1;
         end
      end

      chan_on = {QHBC_CH{run}} & bridge_in.drive_enable_input &
                ~next_st.ocp_latched & ~st.inhibit;
      next_st.gate.high_side_on = chan_on & bridge_in.phase_input;
      next_st.gate.low_side_on  = chan_on & ~bridge_in.phase_input;

      fault_now       = |next_st.ocp_latched || thermal_trip || supply_low_lockout;
      next_st.flag_oe = !fault_now;

      next_st.pump_run = low_power_request_n;

      // events: new latch, thermal rise, supply-low rise
      ev_set = QHBC_EV_NONE;
      ev_set[QHBC_EV_OCP +: QHBC_CH] = next_st.ocp_latched & ~st.ocp_latched;
      ev_set[QHBC_EV_THERM]  = thermal_trip && !st.therm_seen;
      ev_set[QHBC_EV_SUPPLY] = supply_low_lockout && !st.supply_seen;
      next_st.therm_seen  = thermal_trip;
      next_st.supply_seen = supply_low_lockout;

      // register bus answer, loaded in the setup cycle
      next_st.rsp.pready = setup;
      if (setup) begin
         next_st.rsp.pslverr = 1'b0;
         case (apb_req.paddr)
            QHBC_ADR_STATUS: begin
               next_st.rsp.prdata = 32'(status);
            end
            QHBC_ADR_MASK: begin
               next_st.rsp.prdata = 32'(mask);
            end
            QHBC_ADR_STATE: begin
               next_st.rsp.prdata = 32'({!st.flag_oe, st.awake, asleep, supply_low_lockout,
                                         thermal_trip, st.ocp_latched});
            end
            QHBC_ADR_CTRL: begin
               next_st.rsp.prdata = 32'(st.inhibit);
            end
            default: begin
               next_st.rsp.prdata  = 32'h0000_0000;
               next_st.rsp.pslverr = 1'b1;
            end
         endcase
      end
      if (wr_en && apb_req.paddr == QHBC_ADR_CTRL) begin
         next_st.inhibit = apb_req.pwdata[QHBC_CH-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= QHBC_CORE_RST;
      end else begin
         st <= next_st;
      end
   end

   qhbc_irq u_irq (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .ev_set    (ev_set),
      .w1c       (w1c),
      .mask_we   (mask_we),
      .mask_wdata(apb_req.pwdata[QHBC_EV_W-1:0]),
      .status    (status),
      .mask      (mask),
      .irq       (irq)
   );

   assign half_bridge_output    = st.gate;
   // open drain: level and enable share one flop, low drives
   assign trouble_indicator_n_o  = st.flag_oe;
   assign trouble_indicator_n_oe = st.flag_oe;
   assign charge_pump_run        = st.pump_run;
   assign clocks_run             = st.pump_run;
   assign apb_rsp                = st.rsp;

   // helper: consecutive limit cycles on channel 2
   logic [QHBC_DGL_W:0] lim_run2;
   always_ff @(posedge clk) begin
      if (sys_rst || !limit_any[2] || hold_clear || asleep) begin
         lim_run2 <= '0;
      end else if (lim_run2 != '1) begin
         lim_run2 <= lim_run2 + 1'b1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   AST_Z_WHEN_DISABLED: assert property (
      ((half_bridge_output.high_side_on | half_bridge_output.low_side_on) &
       ~$past(bridge_in.drive_enable_input)) == 4'h0)
      else $error("disabled channel still driven");
   AST_PHASE_FOLLOW: assert property (
      run && (bridge_in.drive_enable_input & ~next_st.ocp_latched & ~st.inhibit) == 4'hF
      |=> half_bridge_output.high_side_on == $past(bridge_in.phase_input) &&
          half_bridge_output.low_side_on == ~$past(bridge_in.phase_input))
      else $error("output does not follow phase");
   AST_OCP_CHANNEL_OFF: assert property (
      (st.ocp_latched & (half_bridge_output.high_side_on |
                         half_bridge_output.low_side_on)) == 4'h0)
      else $error("latched channel still driven");
   AST_OCP_DEGLITCH: assert property (
      $rose(st.ocp_latched[2]) |-> $past(lim_run2) == {1'b0, DGL_CYC})
      else $error("overcurrent latched at wrong time");
   AST_OCP_HOLD: assert property (
      logic_clear_n && !supply_low_lockout |=>
      (st.ocp_latched & $past(st.ocp_latched)) == $past(st.ocp_latched))
      else $error("overcurrent latch dropped without clear");
   AST_THERMAL_OFF: assert property (
      thermal_trip |=> half_bridge_output == '0 && !trouble_indicator_n_oe)
      else $error("thermal trip did not disable and flag");
   AST_SUPPLY_LOW: assert property (
      supply_low_lockout |=> half_bridge_output == '0 && st.ocp_latched == 4'h0 &&
                             !trouble_indicator_n_oe)
      else $error("supply low did not reset and flag");
   AST_CLEAR_HOLD: assert property (
      !logic_clear_n |=> half_bridge_output == '0 && st.ocp_latched == 4'h0)
      else $error("logic clear did not hold reset");
   AST_SLEEP_STOP: assert property (
      asleep |=> half_bridge_output == '0 && !charge_pump_run && !clocks_run)
      else $error("sleep did not stop bridges and pump");
   AST_WAKE_QUIET: assert property (
      $rose(low_power_request_n) |=> (half_bridge_output == '0) [*8])
      else $error("bridges driven too soon after wake");
   AST_FLAG_RELEASE: assert property (
      st.ocp_latched == 4'h0 && !$past(thermal_trip) && !$past(supply_low_lockout)
      |-> trouble_indicator_n_oe)
      else $error("fault flag held with no fault");

   // fault pin: level and enable share one flop
   AST_FLAG_PIN_LEVEL: assert property (
      trouble_indicator_n_o == trouble_indicator_n_oe)
      else $error("fault pin level and enable disagree");
   AST_FLAG_ON_LATCH: assert property (
      st.ocp_latched != 4'h0 |-> !trouble_indicator_n_oe)
      else $error("latched overcurrent not flagged");

   // sleep: clocks stop with the pump, wake delay restarts
   AST_CLOCKS_STOP: assert property (
      clocks_run == charge_pump_run)
      else $error("clock and pump run flags disagree");
   AST_SLEEP_RESTARTS_WAKE: assert property (
      asleep |=> !st.awake && st.wake_cnt == '0)
      else $error("sleep did not restart the wake delay");
   AST_PUMP_ON_WAKE: assert property (
      low_power_request_n |=> charge_pump_run)
      else $error("pump not running while awake");
   AST_WAKE_BOUND: assert property (
      st.wake_cnt <= WAKE_CYC - 1'b1)
      else $error("wake counter ran past its end");

   // register bus: zero wait states, ready for one cycle only
   AST_APB_READY: assert property (
      setup |=> apb_rsp.pready)
      else $error("no ready after setup");
   AST_APB_READY_ONE: assert property (
      apb_rsp.pready && !setup |=> !apb_rsp.pready)
      else $error("ready held past the access phase");
   AST_APB_ERR_ZERO: assert property (
      apb_rsp.pready && apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0000_0000)
      else $error("error answer carries data");

   // per channel checks, one copy for each half bridge
   generate
      for (g = 0; g < QHBC_CH; g++) begin : g_chk
         AST_CH_NO_SHOOT: assert property (
            @(posedge clk) disable iff (sys_rst)
            !(half_bridge_output.high_side_on[g] && half_bridge_output.low_side_on[g]))
            else $error("both transistors of one channel on");
         AST_CH_HIGH: assert property (
            @(posedge clk) disable iff (sys_rst)
            run && bridge_in.drive_enable_input[g] && !next_st.ocp_latched[g] && !st.inhibit[g] &&
            bridge_in.phase_input[g] |=> half_bridge_output.high_side_on[g])
            else $error("enabled channel not driven high");
         AST_CH_SLOW_DECAY: assert property (
            @(posedge clk) disable iff (sys_rst)
            run && bridge_in.drive_enable_input[g] && !next_st.ocp_latched[g] && !st.inhibit[g] &&
            !bridge_in.phase_input[g] |=> half_bridge_output.low_side_on[g])
            else $error("slow decay did not short the winding");
         AST_CH_LATCH_CAUSE: assert property (
            @(posedge clk) disable iff (sys_rst)
            $rose(st.ocp_latched[g]) |-> $past(overcurrent_trip[g]))
            else $error("channel latched without a deglitched trip");
         AST_CH_TRIP_LATCHES: assert property (
            @(posedge clk) disable iff (sys_rst)
            overcurrent_trip[g] && !hold_clear |=> st.ocp_latched[g])
            else $error("deglitched trip not latched");
         AST_CH_COUNT_CLEAR: assert property (
            @(posedge clk) disable iff (sys_rst)
            hold_clear || asleep |=> !overcurrent_trip[g])
            else $error("deglitch not cleared by clear or sleep");
         AST_CH_INHIBIT_OFF: assert property (
            @(posedge clk) disable iff (sys_rst)
            st.inhibit[g] |=> !half_bridge_output.high_side_on[g] && !half_bridge_output.low_side_on[g])
            else $error("inhibited channel still driven");
      end
   endgenerate

   COV_OCP_LATCH: cover property ($rose(st.ocp_latched[2]));
   COV_APB_ERROR: cover property (apb_rsp.pready && apb_rsp.pslverr);
   COV_LOW_SIDE_TRIP: cover property (bridge_in.ls_limit[1] && !bridge_in.hs_limit[1]
                                      ##1 $rose(st.ocp_latched[1]));
   COV_THERMAL_RESUME: cover property ($fell(thermal_trip) ##[1:4] |half_bridge_output);
   COV_WAKE_DONE: cover property ($rose(st.awake));

endmodule

// [sim/qhbc_ctrl_model.sv]
`timescale 1ns/100ps
module qhbc_ctrl_model (
   // clock
   input  logic       clk,
   // commands from the bench
   input  logic [1:0] mode,
   input  logic       pwm,
   input  logic [3:0] req_phase,
   input  logic [3:0] req_en,
   // controller pins
   output logic [3:0] phase_input,
   output logic [3:0] drive_enable_input
);
   import qhbc_pkg::*;

   always @(posedge clk) begin
      case (mode)
         2'd1: begin
            // fast decay: chop the enables
            phase_input <= req_phase;
            drive_enable_input <= req_en & {4{pwm}};
         end
         2'd2: begin
            // slow decay: enables held, chop the phase
            phase_input <= req_phase & {4{pwm}};
            drive_enable_input <= req_en;
         end
         default: begin
            phase_input <= req_phase;
            drive_enable_input <= req_en;
         end
      endcase
   end
endmodule

// [sim/qhbc_core_test.sv]
`timescale 1ns/100ps
module qhbc_core_test;
   import qhbc_pkg::*;

   typedef struct packed {
      logic [1:0] mode;
      logic       pwm;
      logic [3:0] ph;
      logic [3:0] en;
      logic [3:0] hi;
      logic [3:0] lo;
   } qhbc_row_t;

   localparam qhbc_row_t ROWS [7] = '{
      '{2'd0, 1'b0, 4'hA, 4'hF, 4'hA, 4'h5},
      '{2'd0, 1'b0, 4'hF, 4'h0, 4'h0, 4'h0},
      '{2'd0, 1'b0, 4'h3, 4'h6, 4'h2, 4'h4},
      '{2'd1, 1'b1, 4'h5, 4'hF, 4'h5, 4'hA},
      '{2'd1, 1'b0, 4'h5, 4'hF, 4'h0, 4'h0},
      '{2'd2, 1'b1, 4'hF, 4'hF, 4'hF, 4'h0},
      '{2'd2, 1'b0, 4'hF, 4'hF, 4'h0, 4'hF}};

   logic            clk = 1'b0;
   logic            sys_rst;
   logic            clr_n;
   logic            slp_n;
   logic            therm;
   logic            sup;
   logic [3:0]      hs;
   logic [3:0]      ls;
   logic [3:0]      ph;
   logic [3:0]      en;
   logic [1:0]      mode;
   logic            pwm;
   logic [3:0]      rph;
   logic [3:0]      ren;
   qhbc_bridge_in_t bin;
   qhbc_gate_t      gate;
   logic            flag_o;
   logic            flag_oe;
   logic            pump;
   logic            clks;
   qhbc_apb_req_t   req;
   qhbc_apb_rsp_t   rsp;
   logic            irq;
   logic [31:0]     rv;
   logic            er;
   int              mismatches = 0;
   int              n_checks = 0;

   assign bin = {ph, en, hs, ls};

   always #5 clk = ~clk;

   qhbc_ctrl_model u_ctrl (.clk(clk), .mode(mode), .pwm(pwm), .req_phase(rph), .req_en(ren),
                           .phase_input(ph), .drive_enable_input(en));

   qhbc_core #(.DGL_CYC(9'd4), .WAKE_CYC(17'd8)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .bridge_in(bin), .logic_clear_n(clr_n),
      .low_power_request_n(slp_n), .thermal_trip(therm), .supply_low_lockout(sup),
      .half_bridge_output(gate), .trouble_indicator_n_o(flag_o), .trouble_indicator_n_oe(flag_oe),
      .charge_pump_run(pump), .clocks_run(clks), .apb_req(req), .apb_rsp(rsp), .irq(irq));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one transfer; waits for pready, the watchdog bounds a hang
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (rsp.pready !== 1'b1);
      rv = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic end_of_test;
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #100us;
      mismatches++;
      end_of_test();
   end

   initial begin
      sys_rst = 1'b1;
      // clear and sleep pins driven high
      clr_n = 1'b1;
      slp_n = 1'b1;
      {therm, sup, hs, ls, mode, pwm, rph, ren} = '0;
      req = '0;
      tick(16);
      chk(gate, 8'h00);
      chk(flag_oe, 1'b1);
      sys_rst <= 1'b0;
      // let the wake delay run out
      tick(12);
      foreach (ROWS[i]) begin
         mode <= ROWS[i].mode;
         pwm <= ROWS[i].pwm;
         rph <= ROWS[i].ph;
         ren <= ROWS[i].en;
         tick(4);
         chk(gate, {ROWS[i].hi, ROWS[i].lo});
      end
      mode <= 2'd0;
      rph <= 4'h0;
      ren <= 4'hF;
      apb(1'b0, QHBC_ADR_STATUS, 32'h0);
      chk(rv, 32'h0000_0000);
      apb(1'b1, QHBC_ADR_CTRL, 32'h0000_0001);
      tick(2);
      chk(gate.low_side_on, 4'hE);
      apb(1'b1, QHBC_ADR_CTRL, 32'h0000_0000);
      apb(1'b0, 8'h10, 32'h0);
      chk(rv, 32'h0000_0000);
      chk(er, 1'b1);
      apb(1'b1, QHBC_ADR_MASK, 32'h0000_003F);
      apb(1'b0, QHBC_ADR_MASK, 32'h0);
      chk(rv, 32'h0000_003F);
      // short limit pulse must not latch
      hs <= 4'h1;
      tick(3);
      hs <= 4'h0;
      tick(4);
      chk(flag_oe, 1'b1);
      hs <= 4'h4;
      ls <= 4'h2;
      tick(8);
      {hs, ls} <= '0;
      tick(2);
      chk(flag_oe, 1'b0);
      chk(flag_o, 1'b0);
      chk(gate.low_side_on, 4'h9);
      chk(irq, 1'b1);
      apb(1'b0, QHBC_ADR_STATUS, 32'h0);
      chk(rv, 32'h0000_0006);
      apb(1'b1, QHBC_ADR_STATUS, 32'h0000_0006);
      tick(3);
      chk(irq, 1'b0);
      chk(gate.low_side_on, 4'h9);
      therm <= 1'b1;
      tick(3);
      chk(gate, 8'h00);
      therm <= 1'b0;
      tick(3);
      chk(gate.low_side_on, 4'h9);
      chk(flag_oe, 1'b0);
      clr_n <= 1'b0;
      tick(3);
      chk(gate, 8'h00);
      clr_n <= 1'b1;
      tick(3);
      chk(gate.low_side_on, 4'hF);
      chk(flag_oe, 1'b1);
      chk(flag_o, 1'b1);
      sup <= 1'b1;
      tick(3);
      chk({gate, flag_oe}, 9'h000);
      apb(1'b0, QHBC_ADR_STATE, 32'h0);
      chk(rv[5], 1'b1);
      sup <= 1'b0;
      tick(3);
      chk({gate.low_side_on, flag_oe}, 5'h1F);
      slp_n <= 1'b0;
      tick(3);
      chk({pump, clks, gate}, 10'h000);
      slp_n <= 1'b1;
      tick(4);
      chk(gate, 8'h00);
      tick(10);
      chk({pump, gate.low_side_on}, 5'h1F);
      end_of_test();
   end
endmodule
